// ---- mac_model.sv ----
// mac side model: sends transmit units, gathers receive bytes
// assumes a free running link clock shared with the device
`timescale 1ns/1ns
`default_nettype none
module mac_model (
   input  wire logic       i_link_clk,
   input  wire logic       i_rmii,
   input  wire logic       i_rx_dv,
   input  wire logic [3:0] i_rxd,
   output logic            o_tx_en,
   output logic [3:0]      o_txd
);
   logic [7:0] rx_q[$];
   logic [3:0] tx_q[$];
   logic [7:0] acc;
   int         cnt;
   initial begin
      o_tx_en = 1'b0;
      o_txd   = 4'ha;
      acc     = 8'h00;
      cnt     = 0;
   end
   // gather units lsb first into bytes
   always @(posedge i_link_clk) begin
      if (i_rx_dv === 1'b1) begin
         acc = i_rmii ? {i_rxd[1:0], acc[7:2]} : {i_rxd, acc[7:4]};
         cnt = cnt + 1;
         if (cnt == (i_rmii ? 4 : 2)) begin
            rx_q.push_back(acc);
            cnt = 0;
         end
      end
   end
   always @(negedge i_link_clk) begin
      if (tx_q.size() > 0) begin
         o_tx_en <= 1'b1;
         o_txd   <= tx_q.pop_front();
      end else begin
         o_tx_en <= 1'b0;
         o_txd   <= ~o_txd; // idle data keeps moving
      end
   end
endmodule : mac_model
`default_nettype wire

// ---- phy_mac_port_params.svh ----
// constants for the mac-facing port, strap and indicator block
// assumes inclusion by bare name from the design file
`ifndef PHY_MAC_PORT_PARAMS_SVH
`define PHY_MAC_PORT_PARAMS_SVH

// interface select strap codes
`define IFSEL_MII        3'h0
`define IFSEL_RMII       3'h1
`define IFSEL_MII_PRE    3'h4

// indicator mode field codes
`define IND_MODE_SPEED   2'h0
`define IND_MODE_ACT     2'h1

// station address layout
`define ADDR_UPPER       2'h0
`define ADDR_DEFAULT_LO  3'h1

// strap reset values (internal pull levels)
`define STRAP_ADDR_RST   3'h1
`define STRAP_IFSEL_RST  3'h0
`define STRAP_SPEED_RST  1'h1

// core cycles of settling after chip reset before straps freeze
`define STRAP_SETTLE     2'h3

// bits carried per link clock and per word
`define MII_BITS         4'h4
`define RMII_BITS        4'h2
`define BYTE_BITS        4'h8

// blink half period
`define CORE_CLK_MHZ     50
`define BLINK_HALF_NS    50000000
`define BLINK_HALF_CYCLES ((`BLINK_HALF_NS / 1000) * `CORE_CLK_MHZ)

`endif

// ---- phy_mac_port_pkg.sv ----
// types for the mac-facing port, strap and indicator block
// assumes nothing beyond a systemverilog compiler
package phy_mac_port_pkg;

   // decoded interface mode, one-hot
   typedef enum logic [3:0] {
      IF_MII     = 4'b0001,
      IF_RMII    = 4'b0010,
      IF_MII_PRE = 4'b0100,
      IF_RSVD    = 4'b1000
   } iface_mode_t;

   // word passed from link to core: end flag, bit count, data
   typedef logic [12:0] tx_word_t;

endpackage : phy_mac_port_pkg

// ---- phy_mac_port_strap_config.sv ----
// mac-facing mii/rmii data port with strap latching and indicator
// assumes i_link_clk is rx/tx clock (mii) or ref clock (rmii), free running
// Operation
// [RULE1] speed mode: indicator high at 10 mbps, low at 100 mbps
// [RULE2] mode 01: indicator high when idle, toggling on activity; 10, 11 reserved
// [RULE3] mii receive: nibble on link clock, valid only while data valid high
// [RULE4] rmii receive: one dibit per ref clock while carrier/data valid high
// [RULE5] mii transmit: mac drives nibble with enable high on valid cycles
// [RULE6] mii transmit: data ignored whenever transmit enable is low
// [RULE7] rmii transmit: mac sends dibit each enabled ref clock, device accepts
// [RULE8] straps sampled during power-up or reset, pins then become outputs
// [RULE9] station address from three address straps, values one to seven
// [RULE10] address upper two bits zero, default address 00001
// [RULE11] interface select 000 mii, 001 rmii, 010 and 011 reserved
// [RULE12] interface select 100 mii with preamble restore, 101-111 reserved
// [RULE13] speed strap sets speed select and advertised speed, pull-up 100
// [RULE14] indicator behaviour chosen by two-bit mode field
// [RULE15] chip reset low resets logic and latches straps
`include "phy_mac_port_params.svh"
`timescale 1ns/1ns
`default_nettype none

module phy_mac_port_strap_config #(
   parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       i_link_clk,
   input  wire logic       i_chip_rst_n,
   input  wire logic       i_station_addr_strap_2,
   input  wire logic       i_station_addr_strap_1,
   input  wire logic       i_station_addr_strap_0,
   input  wire logic       i_interface_select_strap_2,
   input  wire logic       i_interface_select_strap_1,
   input  wire logic       i_interface_select_strap_0,
   input  wire logic       i_speed_activity_indicator,
   input  wire logic [1:0] i_indicator_mode,
   input  wire logic       i_link_up,
   input  wire logic       i_link_100,
   input  wire logic       i_activity,
   input  wire logic       i_rx_valid,
   input  wire logic [7:0] i_rx_byte,
   input  wire logic       i_tx_en,
   input  wire logic [3:0] i_txd,
   output logic            o_rx_ready,
   output logic            o_rx_dv,
   output logic [3:0]      o_rxd,
   output logic            o_tx_valid,
   output logic [7:0]      o_tx_byte,
   output logic [3:0]      o_tx_bits,
   output logic            o_tx_end,
   output logic            o_speed_activity_indicator,
   output logic            o_speed_activity_indicator_oe,
   output logic            o_strap_pins_oe,
   output logic [4:0]      o_station_addr,
   output logic            o_rmii_mode,
   output logic            o_preamble_restore,
   output logic            o_iface_reserved,
   output logic            o_speed_select_100,
   output logic            o_adv_100
);

   // gray code of a two-bit pointer
   function automatic logic [1:0] to_gray(input logic [1:0] b);
      to_gray = b ^ {1'b0, b[1]};
   endfunction : to_gray

   // ****************************************************************
   // strap capture and chip reset (core clock)
   // ****************************************************************
   logic [6:0]  strap_meta;
   logic [6:0]  strap_sync;
   logic [1:0]  chip_rst_meta;
   logic        capture;
   logic [1:0]  settle;
   logic [2:0]  addr_strap;
   logic [2:0]  ifsel_strap;
   logic        speed_strap;
   phy_mac_port_pkg::iface_mode_t mode;

   // two-flop sync of strap pins and chip reset
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         strap_meta    <= 7'h00;
         strap_sync    <= 7'h00;
         chip_rst_meta <= 2'h0;
      end else begin
         strap_meta    <= {i_speed_activity_indicator,
                           i_interface_select_strap_2, i_interface_select_strap_1,
                           i_interface_select_strap_0, i_station_addr_strap_2,
                           i_station_addr_strap_1, i_station_addr_strap_0};
         strap_sync    <= strap_meta;
         chip_rst_meta <= {chip_rst_meta[0], i_chip_rst_n};
      end
   end

   // [RULE15] chip reset holds capture
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         capture <= 1'b1;
         settle  <= 2'h0;
      end else if (!chip_rst_meta[1]) begin
         capture <= 1'b1;
         settle  <= 2'h0;
      end else if (capture) begin
         if (settle == `STRAP_SETTLE)
            capture <= 1'b0;
         else
            settle <= settle + 2'h1;
      end
   end

   // [RULE8] sample straps while capturing
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         addr_strap  <= `STRAP_ADDR_RST;
         ifsel_strap <= `STRAP_IFSEL_RST;
         speed_strap <= `STRAP_SPEED_RST;
      end else if (capture) begin
         addr_strap  <= strap_sync[2:0];
         ifsel_strap <= strap_sync[5:3];
         speed_strap <= strap_sync[6];
      end
   end

   // [RULE11] [RULE12] interface select decode
   always_comb begin
      unique case (ifsel_strap)
         `IFSEL_MII:     mode = phy_mac_port_pkg::IF_MII;
         `IFSEL_RMII:    mode = phy_mac_port_pkg::IF_RMII;
         `IFSEL_MII_PRE: mode = phy_mac_port_pkg::IF_MII_PRE;
         default:        mode = phy_mac_port_pkg::IF_RSVD;
      endcase
   end

   // [RULE9] [RULE10] address, upper bits zero
   assign o_station_addr = {`ADDR_UPPER,
                            (addr_strap == 3'h0) ? `ADDR_DEFAULT_LO : addr_strap};
   assign o_rmii_mode        = (mode == phy_mac_port_pkg::IF_RMII);
   assign o_preamble_restore = (mode == phy_mac_port_pkg::IF_MII_PRE);
   assign o_iface_reserved   = (mode == phy_mac_port_pkg::IF_RSVD);
   // [RULE13] speed strap to select and advert
   assign o_speed_select_100 = speed_strap;
   assign o_adv_100          = speed_strap;
   // [RULE8] pins revert to outputs
   assign o_strap_pins_oe    = !capture;

   // ****************************************************************
   // link domain control crossing
   // ****************************************************************
   logic [1:0]  hold_meta;
   logic [1:0]  rmii_meta;
   logic        lnk_hold;
   logic        lnk_rmii;

   // two-flop sync of capture and mode levels
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_meta <= 2'h3;
         rmii_meta <= 2'h0;
      end else begin
         hold_meta <= {hold_meta[0], capture};
         rmii_meta <= {rmii_meta[0], o_rmii_mode};
      end
   end
   assign lnk_hold = hold_meta[1];
   assign lnk_rmii = rmii_meta[1];

   // ****************************************************************
   // transmit: link packing into four-slot crossing
   // ****************************************************************
   phy_mac_port_pkg::tx_word_t tx_slot [4];
   phy_mac_port_pkg::tx_word_t tx_word;
   logic [7:0]  tx_sh;
   logic [7:0]  tx_new_sh;
   logic [3:0]  tx_cnt;
   logic [3:0]  tx_sum;
   logic        tx_en_d;
   logic        push_full;
   logic        tx_push;
   logic [1:0]  tx_wbin;
   logic [1:0]  tx_wgray;

   // [RULE6] [RULE7] shift only enabled cycles
   always_comb begin
      tx_new_sh = lnk_rmii ? {i_txd[1:0], tx_sh[7:2]} : {i_txd, tx_sh[7:4]};
      tx_sum    = tx_cnt + (lnk_rmii ? `RMII_BITS : `MII_BITS);
      push_full = i_tx_en && (tx_sum == `BYTE_BITS);
      tx_push   = push_full || (!i_tx_en && tx_en_d);
      tx_word   = push_full ? {1'b0, `BYTE_BITS, tx_new_sh}
                            : {1'b1, tx_cnt, 8'(tx_sh >> (`BYTE_BITS - tx_cnt))};
   end

   // packing shifter and frame end tracking
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_sh   <= 8'h00;
         tx_cnt  <= 4'h0;
         tx_en_d <= 1'b0;
      end else if (lnk_hold) begin
         tx_sh   <= 8'h00;
         tx_cnt  <= 4'h0;
         tx_en_d <= 1'b0;
      end else begin
         tx_en_d <= i_tx_en;
         if (i_tx_en) begin
            tx_sh  <= tx_new_sh;
            tx_cnt <= push_full ? 4'h0 : tx_sum;
         end else begin
            tx_cnt <= 4'h0;
         end
      end
   end

   // slot write and gray write pointer
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_wbin  <= 2'h0;
         tx_wgray <= 2'h0;
      end else if (lnk_hold) begin
         tx_wbin  <= 2'h0;
         tx_wgray <= 2'h0;
      end else if (tx_push) begin
         tx_wbin  <= tx_wbin + 2'h1;
         tx_wgray <= to_gray(tx_wbin + 2'h1);
      end
   end

   // slot storage, no reset needed
   always_ff @(posedge i_link_clk) begin
      if (tx_push)
         tx_slot[tx_wbin] <= tx_word;
   end

   // ****************************************************************
   // transmit: core side unload
   // ****************************************************************
   logic [1:0]  wg_meta;
   logic [1:0]  wg_sync;
   logic [1:0]  tx_rbin;
   logic        tx_pop;

   assign tx_pop = (to_gray(tx_rbin) != wg_sync);

   // pointer sync, one word out per pop
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wg_meta    <= 2'h0;
         wg_sync    <= 2'h0;
         tx_rbin    <= 2'h0;
         o_tx_valid <= 1'b0;
         o_tx_byte  <= 8'h00;
         o_tx_bits  <= 4'h0;
         o_tx_end   <= 1'b0;
      end else if (capture) begin
         wg_meta    <= 2'h0;
         wg_sync    <= 2'h0;
         tx_rbin    <= 2'h0;
         o_tx_valid <= 1'b0;
      end else begin
         wg_meta    <= tx_wgray;
         wg_sync    <= wg_meta;
         o_tx_valid <= tx_pop;
         if (tx_pop) begin
            tx_rbin   <= tx_rbin + 2'h1;
            o_tx_end  <= tx_slot[tx_rbin][12];
            o_tx_bits <= tx_slot[tx_rbin][11:8];
            o_tx_byte <= tx_slot[tx_rbin][7:0];
         end
      end
   end

   // ****************************************************************
   // receive: two-entry buffer and handshake (core clock)
   // ****************************************************************
   logic [7:0]  rx_buf [2];
   logic        rx_wp;
   logic        rx_rp;
   logic [1:0]  rx_cnt;
   logic        rx_push;
   logic        rx_pop;
   logic        rx_req;
   logic [1:0]  ack_meta;
   logic        rx_busy;
   logic [7:0]  rx_hold;
   logic        rx_ack;

   assign o_rx_ready = (rx_cnt != 2'h2) && !capture;
   assign rx_push    = i_rx_valid && o_rx_ready;
   assign rx_busy    = (rx_req != ack_meta[1]);
   assign rx_pop     = (rx_cnt != 2'h0) && !rx_busy && !capture;

   // buffer pointers and occupancy
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_wp  <= 1'b0;
         rx_rp  <= 1'b0;
         rx_cnt <= 2'h0;
      end else if (capture) begin
         rx_wp  <= 1'b0;
         rx_rp  <= 1'b0;
         rx_cnt <= 2'h0;
      end else begin
         if (rx_push)
            rx_wp <= !rx_wp;
         if (rx_pop)
            rx_rp <= !rx_rp;
         rx_cnt <= rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
      end
   end

   // buffer storage
   always_ff @(posedge i_core_clk) begin
      if (rx_push)
         rx_buf[rx_wp] <= i_rx_byte;
   end

   // request toggle with held word, ack sync
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_req   <= 1'b0;
         rx_hold  <= 8'h00;
         ack_meta <= 2'h0;
      end else begin
         ack_meta <= {ack_meta[0], rx_ack};
         if (rx_pop) begin
            rx_req  <= !rx_req;
            rx_hold <= rx_buf[rx_rp];
         end
      end
   end

   // ****************************************************************
   // receive: link serialiser
   // ****************************************************************
   logic [1:0]  rq_meta;
   logic [7:0]  rx_sh;
   logic [3:0]  rx_left;
   logic [3:0]  rx_step;
   logic        rx_load;

   assign rx_step = lnk_rmii ? `RMII_BITS : `MII_BITS;
   assign rx_load = ((rx_left == 4'h0) || (rx_left == rx_step))
                    && (rq_meta[1] != rx_ack) && !lnk_hold;

   // [RULE3] [RULE4] data valid only with data
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         rq_meta <= 2'h0;
         rx_ack  <= 1'b0;
         rx_sh   <= 8'h00;
         rx_left <= 4'h0;
         o_rx_dv <= 1'b0;
         o_rxd   <= 4'h0;
      end else begin
         rq_meta <= {rq_meta[0], rx_req};
         if (rx_left != 4'h0 && !lnk_hold) begin
            o_rx_dv <= 1'b1;
            o_rxd   <= lnk_rmii ? {2'h0, rx_sh[1:0]} : rx_sh[3:0];
            rx_sh   <= lnk_rmii ? (rx_sh >> 2) : (rx_sh >> 4);
            rx_left <= rx_left - rx_step;
         end else begin
            o_rx_dv <= 1'b0;
            o_rxd   <= 4'h0;
            rx_left <= 4'h0;
         end
         if (rx_load) begin
            rx_sh   <= rx_hold;
            rx_left <= `BYTE_BITS;
            rx_ack  <= rq_meta[1];
         end
      end
   end

   // ****************************************************************
   // indicator
   // ****************************************************************
   logic [31:0] blink_cnt;
   logic        blink_wrap;
   logic        act_seen;
   logic        blink_lvl;
   logic        next_ind;

   assign blink_wrap = (blink_cnt == BLINK_HALF_CYCLES - 1);

   // [RULE2] blink while activity seen
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         blink_cnt <= 32'h0;
         act_seen  <= 1'b0;
         blink_lvl <= 1'b1;
      end else if (capture) begin
         blink_cnt <= 32'h0;
         act_seen  <= 1'b0;
         blink_lvl <= 1'b1;
      end else begin
         blink_cnt <= blink_wrap ? 32'h0 : blink_cnt + 32'h1;
         if (blink_wrap) begin
            blink_lvl <= act_seen ? !blink_lvl : 1'b1;
            act_seen  <= i_activity || rx_push || tx_pop;
         end else if (i_activity || rx_push || tx_pop) begin
            act_seen <= 1'b1;
         end
      end
   end

   // [RULE14] [RULE1] mode select of pin level
   always_comb begin
      unique case (i_indicator_mode)
         `IND_MODE_SPEED: next_ind = !(i_link_up && i_link_100);
         `IND_MODE_ACT:   next_ind = blink_lvl;
         default:         next_ind = 1'b1;
      endcase
   end

   // indicator pin, input during capture
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         o_speed_activity_indicator <= 1'b1;
      else
         o_speed_activity_indicator <= next_ind;
   end
   assign o_speed_activity_indicator_oe = !capture;

endmodule : phy_mac_port_strap_config

`default_nettype wire

// ---- phy_mac_port_strap_config_chk.sv ----
// checker for the mac port, strap and indicator block
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module phy_mac_port_strap_config_chk (
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic       i_link_clk,
   input wire logic       i_chip_rst_n,
   input wire logic       i_speed_activity_indicator,
   input wire logic [1:0] i_indicator_mode,
   input wire logic       i_link_up,
   input wire logic       i_link_100,
   input wire logic       o_rx_dv,
   input wire logic [3:0] o_rxd,
   input wire logic       o_tx_valid,
   input wire logic [7:0] o_tx_byte,
   input wire logic [3:0] o_tx_bits,
   input wire logic       o_tx_end,
   input wire logic       o_speed_activity_indicator,
   input wire logic       o_strap_pins_oe,
   input wire logic [4:0] o_station_addr,
   input wire logic       o_rmii_mode,
   input wire logic       o_preamble_restore,
   input wire logic       o_iface_reserved,
   input wire logic       o_speed_select_100,
   input wire logic       o_adv_100
);
   // ****
   // properties
   // ****
   sequence s_chip_held;
      !i_chip_rst_n [*5];
   endsequence
   a_addr_upper_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_station_addr[4:3] == 2'h0 && o_station_addr[2:0] != 3'h0) else $error("station address out of range");
   a_speed_level: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_indicator_mode == 2'h0 && $past(i_indicator_mode) == 2'h0 && o_strap_pins_oe && $past(o_strap_pins_oe)
      |-> o_speed_activity_indicator == !($past(i_link_up) && $past(i_link_100))) else $error("speed level wrong");
   a_ind_reserved: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_indicator_mode[1] && $past(i_indicator_mode[1]) && o_strap_pins_oe && $past(o_strap_pins_oe)
      |-> o_speed_activity_indicator) else $error("reserved mode not off");
   a_rxd_idle: assert property (@(posedge i_link_clk) disable iff (i_rst)
      !o_rx_dv |-> o_rxd == 4'h0) else $error("rx data while not valid");
   a_rmii_dibit: assert property (@(posedge i_link_clk) disable iff (i_rst)
      o_rmii_mode && o_rx_dv |-> o_rxd[3:2] == 2'h0) else $error("rmii upper bits set");
   a_tx_bits: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_tx_valid |-> (o_tx_end ? o_tx_bits < 4'h8 : o_tx_bits == 4'h8)) else $error("tx bit count wrong");
   a_tx_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_strap_pins_oe && $past(o_strap_pins_oe) && $past(i_chip_rst_n) && $past(i_chip_rst_n, 2) && !o_tx_valid
      |-> $stable(o_tx_byte) && $stable(o_tx_end)) else $error("tx word moved without pulse");
   a_chip_reset_oe: assert property (@(posedge i_core_clk) disable iff (i_rst)
      s_chip_held |-> !o_strap_pins_oe) else $error("pins driven during chip reset");
   a_cfg_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_strap_pins_oe && $past(o_strap_pins_oe) |-> $stable(o_station_addr) && $stable(o_rmii_mode))
      else $error("config moved after latch");
   a_mode_decode: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_rmii_mode |-> !o_preamble_restore && !o_iface_reserved) else $error("mode decode overlap");
   a_speed_strap: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_speed_select_100 == o_adv_100
      && (!$rose(o_strap_pins_oe) || o_adv_100 == $past(i_speed_activity_indicator, 3)))
      else $error("speed strap latch wrong");
endmodule : phy_mac_port_strap_config_chk
bind phy_mac_port_strap_config phy_mac_port_strap_config_chk i_chk (.i_core_clk, .i_rst, .i_link_clk,
   .i_chip_rst_n, .i_speed_activity_indicator, .i_indicator_mode, .i_link_up, .i_link_100, .o_rx_dv, .o_rxd,
   .o_tx_valid, .o_tx_byte,
   .o_tx_bits, .o_tx_end, .o_speed_activity_indicator, .o_strap_pins_oe, .o_station_addr, .o_rmii_mode,
   .o_preamble_restore, .o_iface_reserved, .o_speed_select_100, .o_adv_100);
`default_nettype wire

// ---- phy_mac_port_strap_config_tb.sv ----
// testbench: straps, indicator modes, mii and rmii data both ways
// assumes design, checker and mac_model compiled before it
`timescale 1ns/1ns
`default_nettype none
module phy_mac_port_strap_config_tb;
   // ****
   // stimulus and checks
   // ****
   logic        i_core_clk, i_rst, i_link_clk, i_chip_rst_n, i_link_up, i_link_100, i_activity, spd;
   logic        i_station_addr_strap_2, i_station_addr_strap_1, i_station_addr_strap_0;
   logic        i_interface_select_strap_2, i_interface_select_strap_1, i_interface_select_strap_0;
   logic        i_rx_valid, o_rx_ready, o_rx_dv, o_tx_valid, o_tx_end, o_speed_activity_indicator;
   logic        o_speed_activity_indicator_oe, o_strap_pins_oe, o_rmii_mode, o_preamble_restore;
   logic        o_iface_reserved, o_speed_select_100, o_adv_100, i_tx_en;
   logic [1:0]  i_indicator_mode;
   logic [3:0]  i_txd, o_rxd, o_tx_bits;
   logic [4:0]  o_station_addr;
   logic [7:0]  i_rx_byte, o_tx_byte;
   logic [12:0] tx_got[$];
   logic [7:0]  rx_exp[$];
   wire         i_speed_activity_indicator;
   int          error_cnt, n_checks, cyc, t;
   // shared indicator and speed strap pin
   assign i_speed_activity_indicator = o_speed_activity_indicator_oe ? o_speed_activity_indicator : spd;
   phy_mac_port_strap_config #(.BLINK_HALF_CYCLES(8)) i_dut (.*);
   mac_model i_mac (.i_link_clk, .i_rmii(o_rmii_mode), .i_rx_dv(o_rx_dv), .i_rxd(o_rxd), .o_tx_en(i_tx_en),
      .o_txd(i_txd));
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #7;
      forever #15 i_link_clk = ~i_link_clk;
   end
   // word capture and hang limit
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (o_tx_valid === 1'b1) tx_got.push_back({o_tx_end, o_tx_bits, o_tx_byte});
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wrap_up;
      if (error_cnt == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   task automatic strap_reset(input logic [2:0] a, input logic [2:0] f, input logic s);
      int w;
      {i_station_addr_strap_2, i_station_addr_strap_1, i_station_addr_strap_0} = a;
      {i_interface_select_strap_2, i_interface_select_strap_1, i_interface_select_strap_0} = f;
      spd = s;
      i_chip_rst_n = 1'b0;
      repeat (6) @(negedge i_core_clk);
      i_chip_rst_n = 1'b1;
      w = 0;
      while (o_strap_pins_oe !== 1'b1 && w < 50) begin
         @(negedge i_core_clk);
         w++;
      end
      repeat (6) @(negedge i_core_clk);
      chk("pins_oe", 13'h1, o_strap_pins_oe);
      chk("ind_oe", 13'h1, o_speed_activity_indicator_oe);
   endtask : strap_reset
   task automatic count_toggles(input int n, output int c);
      logic last;
      c = 0;
      last = o_speed_activity_indicator;
      repeat (n) begin
         @(negedge i_core_clk);
         if (o_speed_activity_indicator !== last) c++;
         last = o_speed_activity_indicator;
      end
   endtask : count_toggles
   task automatic rx_burst(input int n, input logic [7:0] base);
      int   i, w, stall;
      logic took;
      i = 0;
      w = 0;
      stall = 0;
      i_mac.rx_q.delete();
      rx_exp.delete();
      i_rx_valid = 1'b1;
      while (i < n && w < 400) begin
         i_rx_byte = base + 8'(i);
         took = o_rx_ready;
         @(negedge i_core_clk);
         w++;
         if (took === 1'b1) begin
            rx_exp.push_back(i_rx_byte);
            i++;
         end else stall++;
      end
      i_rx_valid = 1'b0;
      w = 0;
      while (i_mac.rx_q.size() < n && w < 400) begin
         @(negedge i_core_clk);
         w++;
      end
      chk("rx_refused", 13'h1, 13'(stall > 0));
      chk("rx_count", 13'(n), 13'(i_mac.rx_q.size()));
      foreach (rx_exp[k]) if (k < i_mac.rx_q.size()) chk("rx_byte", rx_exp[k], i_mac.rx_q[k]);
      chk("rx_ready", 13'h1, o_rx_ready);
   endtask : rx_burst
   task automatic tx_frame(input logic [3:0] u[$], input logic [12:0] e[$]);
      int w;
      tx_got.delete();
      i_mac.tx_q = u;
      w = 0;
      while (tx_got.size() < e.size() && w < 200) begin
         @(negedge i_core_clk);
         w++;
      end
      repeat (10) @(negedge i_core_clk);
      chk("tx_words", 13'(e.size()), 13'(tx_got.size()));
      foreach (e[k]) if (k < tx_got.size()) chk("tx_word", e[k], tx_got[k]);
   endtask : tx_frame
   // main sequence
   initial begin
      {error_cnt, n_checks, cyc} = '0;
      {i_rst, i_chip_rst_n, spd} = 3'h7;
      {i_station_addr_strap_2, i_station_addr_strap_1, i_station_addr_strap_0} = 3'h1;
      {i_interface_select_strap_2, i_interface_select_strap_1, i_interface_select_strap_0} = 3'h0;
      {i_link_up, i_link_100, i_activity, i_rx_valid, i_indicator_mode, i_rx_byte} = '0;
      repeat (2) @(negedge i_core_clk);
      chk("rst_addr", 13'h1, o_station_addr);
      i_rst = 1'b0;
      for (int k = 0; k < 8; k++) begin
         strap_reset(k[2:0], k[2:0], k[0]);
         chk("addr", (k == 0) ? 13'h1 : 13'(k), o_station_addr);
         chk("rmii", 13'(k == 1), o_rmii_mode);
         chk("pre", 13'(k == 4), o_preamble_restore);
         chk("rsvd", 13'(k inside {2, 3, 5, 6, 7}), o_iface_reserved);
         chk("spd", {11'h0, {2{k[0]}}}, {o_speed_select_100, o_adv_100});
      end
      {i_station_addr_strap_2, i_station_addr_strap_1, i_station_addr_strap_0} = 3'h2;
      repeat (5) @(negedge i_core_clk);
      chk("addr_hold", 13'h7, o_station_addr);
      strap_reset(3'h0, 3'h0, 1'b1);
      for (int k = 0; k < 4; k++) begin
         {i_link_up, i_link_100} = k[1:0];
         repeat (3) @(negedge i_core_clk);
         chk("ind_speed", 13'(k != 3), o_speed_activity_indicator);
      end
      for (int m = 2; m < 4; m++) begin
         i_indicator_mode = m[1:0];
         repeat (3) @(negedge i_core_clk);
         chk("ind_rsvd", 13'h1, o_speed_activity_indicator);
      end
      i_indicator_mode = 2'h1;
      i_activity = 1'b1;
      count_toggles(48, t);
      chk("blink", 13'h1, 13'(t >= 4));
      i_activity = 1'b0;
      repeat (24) @(negedge i_core_clk);
      count_toggles(32, t);
      chk("idle_toggles", 13'h0, 13'(t));
      chk("idle_level", 13'h1, o_speed_activity_indicator);
      rx_burst(8, 8'hc3);
      tx_frame('{4'h1, 4'h2, 4'h3}, '{13'h0821, 13'h1403});
      tx_frame('{4'h4, 4'h5}, '{13'h0854, 13'h1000});
      strap_reset(3'h2, 3'h1, 1'b0);
      rx_burst(6, 8'h5a);
      tx_frame('{4'h1, 4'h2, 4'h3, 4'h0, 4'h2}, '{13'h0839, 13'h1202});
      wrap_up();
   end
endmodule : phy_mac_port_strap_config_tb
`default_nettype wire
